/* File: xlat_defines.svh */
/*
 * offsets, field positions, identification values and fixed feature values of the
 * interrupt translation service register block.
 * assumes byte addressing on the register port, one aligned word per register.
 */
`ifndef XLAT_DEFINES_SVH
`define XLAT_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONTROL      16'h0000
`define OFS_IDENT        16'h0004
`define OFS_FEAT_LO      16'h0008
`define OFS_FEAT_HI      16'h000C
`define OFS_DOORBELL     16'h0040
`define OFS_QBASE_LO     16'h0080
`define OFS_QBASE_HI     16'h0084
`define OFS_QWRITE_LO    16'h0088
`define OFS_QWRITE_HI    16'h008C
`define OFS_QREAD_LO     16'h0090
`define OFS_QREAD_HI     16'h0094

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_ENABLE_BIT  0
`define CTRL_QUIET_BIT   31
`define PTR_RESUME_BIT   0
`define PTR_STALL_BIT    0
`define PTR_OFS_HI       19
`define PTR_OFS_LO       5
`define QBASE_SIZE_HI    7

// ****************************************************************
// identification, values arbitrary
// ****************************************************************
`define ID_PRODUCT       8'h5A
`define ID_VARIANT       4'h1
`define ID_REVISION      4'h2
`define ID_CONT_CODE     4'h2
`define ID_MAKER_CODE    7'h15

// ****************************************************************
// implemented sizes and feature values
// ****************************************************************
`define DEV_BITS         4
`define EVT_BITS         4
`define DEV_COUNT        16
`define EVT_COUNT        16
`define FEAT_ITT_SIZE    4'h7
`define FEAT_VPE_MOVE    1'b0
`define FEAT_CID_LIMIT   1'b0
`define PAGE_UNITS       16'h0080

`endif

/* File: xlat_pkg.sv */
/*
 * types of the interrupt translation service register block.
 * assumes xlat_defines.svh is on the include path.
 */
`include "xlat_defines.svh"

package xlat_pkg;

	// register port request, requester id rides with every access
	typedef struct packed {
		logic                 req;
		logic                 we;
		logic [15:0]          addr;
		logic [31:0]          wdata;
		logic [3:0]           be;
		logic [`DEV_BITS-1:0] req_id;
	} reg_req_t;

	// map-device result from the command executor
	typedef struct packed {
		logic                 valid;
		logic [`DEV_BITS-1:0] id;
		logic                 mapped;
		logic [4:0]           width;
	} map_dev_t;

	// map-event result from the command executor
	typedef struct packed {
		logic                 valid;
		logic [`DEV_BITS-1:0] id;
		logic [`EVT_BITS-1:0] event_number;
		logic                 mapped;
	} map_evt_t;

	// accepted translation request
	typedef struct packed {
		logic                 valid;
		logic [`DEV_BITS-1:0] id;
		logic [31:0]          event_number;
	} xlate_t;

	typedef enum logic [0:0] {
		CQ_IDLE,
		CQ_WAIT
	} cq_state_t;

endpackage

/* File: msi_translation_service_regs.sv */
/*
 * register block of the interrupt translation service: control, ident,
 * features, command queue base/write/read pointers and the doorbell.
 * assumes a simple register port (one request per cycle, answer one cycle
 * later) and an outside command executor that fetches and runs commands.
 */
`timescale 1ns/100ps
`include "xlat_defines.svh"

module msi_translation_service_regs (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire xlat_pkg::reg_req_t       reg_in,
	output logic [31:0]                   reg_rdata,
	output logic                          reg_ack,
	output logic                          cmd_fetch_valid,
	output logic [19:0]                   cmd_fetch_offset,
	input  wire logic                     cmd_done,
	input  wire logic                     cmd_error,
	input  wire xlat_pkg::map_dev_t       map_dev,
	input  wire xlat_pkg::map_evt_t       map_evt,
	output xlat_pkg::xlate_t              xlate_out,
	output logic                          doorbell_drop,
	output logic                          sys_error
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic                         enable_q;
	logic [31:0]                  qbase_lo_q;
	logic [31:0]                  qbase_hi_q;
	logic [14:0]                  wr_ofs_q;
	logic [14:0]                  rd_ofs_q;
	logic                         stalled_q;
	xlat_pkg::cq_state_t          state_q;
	logic                         dev_mapped_q [`DEV_COUNT];
	logic [4:0]                   dev_width_q  [`DEV_COUNT];
	logic [`EVT_COUNT-1:0]        evt_mapped_q [`DEV_COUNT];
	logic [31:0]                  reg_rdata_q;
	logic                         reg_ack_q;
	logic                         fetch_valid_q;
	xlat_pkg::xlate_t             xlate_q;
	logic                         drop_q;
	logic                         sys_error_q;
	logic                         ack_was_qwlo_q;

	// ****************************************************************
	// address decode
	// ****************************************************************
	wire logic        wr_en     = reg_in.req && reg_in.we;
	wire logic        rd_en     = reg_in.req && !reg_in.we;
	wire logic        hit_ctrl  = reg_in.addr == `OFS_CONTROL;
	wire logic        hit_db    = reg_in.addr == `OFS_DOORBELL;
	wire logic        hit_qblo  = reg_in.addr == `OFS_QBASE_LO;
	wire logic        hit_qbhi  = reg_in.addr == `OFS_QBASE_HI;
	wire logic        hit_qwlo  = reg_in.addr == `OFS_QWRITE_LO;
	wire logic        wr_ctrl   = wr_en && hit_ctrl;
	wire logic        wr_db     = wr_en && hit_db;
	wire logic        wr_qbase  = wr_en && (hit_qblo || hit_qbhi);
	wire logic        wr_qwlo   = wr_en && hit_qwlo;

	// byte lanes not written are taken as zero
	wire logic [31:0] lane_mask = {{8{reg_in.be[3]}}, {8{reg_in.be[2]}},
	                               {8{reg_in.be[1]}}, {8{reg_in.be[0]}}};
	wire logic [31:0] wdata_m   = reg_in.wdata & lane_mask;

	// ****************************************************************
	// queue geometry
	// ****************************************************************
	// limit in 32-byte units: 128 * (size + 1)
	wire logic [15:0] q_limit   = 16'((16'(qbase_lo_q[`QBASE_SIZE_HI:0]) + 16'h0001) * `PAGE_UNITS);
	wire logic        q_invalid = {1'b0, wr_ofs_q} >= q_limit;
	wire logic [14:0] rd_inc    = 15'(rd_ofs_q + 15'h0001);
	wire logic [14:0] rd_next   = ({1'b0, rd_inc} >= q_limit) ? 15'h0000 : rd_inc;
	wire logic [14:0] new_wr    = wdata_m[`PTR_OFS_HI:`PTR_OFS_LO];
	wire logic        new_bad   = {1'b0, new_wr} >= q_limit;

	// ****************************************************************
	// command processing control
	// ****************************************************************
	wire logic        err_done  = (state_q == xlat_pkg::CQ_WAIT) && cmd_done && cmd_error;
	wire logic        ok_done   = (state_q == xlat_pkg::CQ_WAIT) && cmd_done && !cmd_error;
	wire logic        resume_wr = wr_qwlo && reg_in.be[0] && wdata_m[`PTR_RESUME_BIT];
	wire logic        can_fetch = enable_q && !stalled_q && !q_invalid
	                              && (rd_ofs_q != wr_ofs_q);
	wire logic        quiet     = !enable_q && (state_q == xlat_pkg::CQ_IDLE);

	// ****************************************************************
	// doorbell checks
	// ****************************************************************
	wire logic [`DEV_BITS-1:0] db_id  = reg_in.req_id;
	wire logic [31:0]          db_evt = wdata_m;
	wire logic [4:0]           db_w   = dev_width_q[db_id];
	wire logic                 evt_over_impl = |db_evt[31:`EVT_BITS];
	wire logic [5:0]           evt_span = 6'(db_w) + 6'h01;
	wire logic                 evt_over_dev  = (evt_span < 6'h20) && ((db_evt >> evt_span) != 32'h0000_0000);
	wire logic                 evt_unmapped  = !evt_mapped_q[db_id][db_evt[`EVT_BITS-1:0]];
	// requester id is never wider than the port, so that discard cannot arise
	wire logic                 db_accept = enable_q && dev_mapped_q[db_id] && !evt_over_impl
	                                       && !evt_over_dev && !evt_unmapped;

	// ****************************************************************
	// read data
	// ****************************************************************
	wire logic [31:0] ident_val = {`ID_PRODUCT, 4'h0, `ID_VARIANT, `ID_REVISION,
	                               `ID_CONT_CODE, 1'b0, `ID_MAKER_CODE};
	wire logic [31:0] feat_lo   = {8'h00, 4'h0, 1'b0, 1'b0, 5'(`DEV_BITS-1), 5'(`EVT_BITS-1),
	                               `FEAT_ITT_SIZE, 1'b0, 1'b0, 1'b0, 1'b1};
	wire logic [31:0] feat_hi   = {26'h0, `FEAT_VPE_MOVE, `FEAT_CID_LIMIT, 4'h0};
	wire logic [31:0] rd_mux    =
		(reg_in.addr == `OFS_CONTROL)   ? {quiet, 30'h0, enable_q} :
		(reg_in.addr == `OFS_IDENT)     ? ident_val :
		(reg_in.addr == `OFS_FEAT_LO)   ? feat_lo :
		(reg_in.addr == `OFS_FEAT_HI)   ? feat_hi :
		(reg_in.addr == `OFS_QBASE_LO)  ? qbase_lo_q :
		(reg_in.addr == `OFS_QBASE_HI)  ? qbase_hi_q :
		(reg_in.addr == `OFS_QWRITE_LO) ? {12'h000, wr_ofs_q, 5'h00} :
		(reg_in.addr == `OFS_QREAD_LO)  ? {12'h000, rd_ofs_q, 4'h0, stalled_q} :
		32'h0000_0000;

	// ****************************************************************
	// register bus answer
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_ack_q      <= 1'b0;
			reg_rdata_q    <= 32'h0000_0000;
			ack_was_qwlo_q <= 1'b0;
		end else begin
			reg_ack_q      <= reg_in.req;
			reg_rdata_q    <= rd_en ? rd_mux : 32'h0000_0000;
			ack_was_qwlo_q <= rd_en && hit_qwlo;
		end
	end

	// ****************************************************************
	// control, base and write pointer registers
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable_q    <= 1'b0;
			qbase_lo_q  <= 32'h0000_0000;
			qbase_hi_q  <= 32'h0000_0000;
			wr_ofs_q    <= 15'h0000;
			sys_error_q <= 1'b0;
		end else begin
			if (wr_ctrl && reg_in.be[0])
				enable_q <= wdata_m[`CTRL_ENABLE_BIT];
			if (wr_en && hit_qblo)
				qbase_lo_q <= wdata_m & 32'hFFFF_FCFF;
			if (wr_en && hit_qbhi)
				qbase_hi_q <= wdata_m & 32'hFFEF_FFFF;
			if (wr_qwlo)
				wr_ofs_q <= new_wr;
			sys_error_q <= wr_qwlo && new_bad;
		end
	end

	// ****************************************************************
	// command queue engine
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q       <= xlat_pkg::CQ_IDLE;
			rd_ofs_q      <= 15'h0000;
			stalled_q     <= 1'b0;
			fetch_valid_q <= 1'b0;
		end else begin
			fetch_valid_q <= 1'b0;
			case (state_q)
				xlat_pkg::CQ_IDLE: begin
					if (can_fetch) begin
						fetch_valid_q <= 1'b1;
						state_q       <= xlat_pkg::CQ_WAIT;
					end
				end
				xlat_pkg::CQ_WAIT: begin
					if (cmd_done)
						state_q <= xlat_pkg::CQ_IDLE;
				end
				default: state_q <= xlat_pkg::CQ_IDLE;
			endcase
			if (wr_qbase)
				rd_ofs_q <= 15'h0000;
			else if (ok_done)
				rd_ofs_q <= rd_next;
			// a new error wins over a resume in the same cycle
			if (err_done)
				stalled_q <= 1'b1;
			else if (resume_wr)
				stalled_q <= 1'b0;
		end
	end

	// ****************************************************************
	// device and event tables
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < `DEV_COUNT; i++) begin
				dev_mapped_q[i] <= 1'b0;
				dev_width_q[i]  <= 5'h00;
				evt_mapped_q[i] <= '0;
			end
		end else begin
			if (map_dev.valid) begin
				dev_mapped_q[map_dev.id] <= map_dev.mapped;
				dev_width_q[map_dev.id]  <= map_dev.width;
				evt_mapped_q[map_dev.id] <= '0;
			end
			if (map_evt.valid && !(map_dev.valid && map_dev.id == map_evt.id))
				evt_mapped_q[map_evt.id][map_evt.event_number] <= map_evt.mapped;
		end
	end

	// ****************************************************************
	// doorbell translation
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			xlate_q <= '0;
			drop_q  <= 1'b0;
		end else begin
			xlate_q.valid        <= wr_db && db_accept;
			xlate_q.id           <= db_id;
			xlate_q.event_number <= db_evt;
			drop_q               <= wr_db && !db_accept;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata        = reg_rdata_q;
	assign reg_ack          = reg_ack_q;
	assign cmd_fetch_valid  = fetch_valid_q;
	assign cmd_fetch_offset = {rd_ofs_q, 5'h00};
	assign xlate_out        = xlate_q;
	assign doorbell_drop    = drop_q;
	assign sys_error        = sys_error_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	resume_reads_zero_a: assert property (reg_ack_q && ack_was_qwlo_q |-> reg_rdata_q[0] == 1'b0)
		else $error("resume bit read back non-zero");
	error_sets_stall_a: assert property (err_done |=> stalled_q)
		else $error("command error did not stall");
	resume_clears_stall_a: assert property (stalled_q && resume_wr && !err_done |=> !stalled_q)
		else $error("resume did not restart");
	zero_resume_holds_a: assert property (stalled_q && wr_qwlo && !wdata_m[0] |=> stalled_q)
		else $error("zero resume changed stall");
	disabled_drop_a: assert property (wr_db && !enable_q |=> drop_q && !xlate_q.valid)
		else $error("doorbell taken while disabled");
	stall_no_fetch_a: assert property (stalled_q && state_q == xlat_pkg::CQ_IDLE |=> !fetch_valid_q)
		else $error("fetch while stalled");
	empty_no_fetch_a: assert property (rd_ofs_q == wr_ofs_q |=> !fetch_valid_q)
		else $error("fetch with empty queue");
	ident_fields_a: assert property (rd_en && reg_in.addr == `OFS_IDENT
		|=> reg_rdata_q[23:20] == 4'h0 && reg_rdata_q[7] == 1'b0)
		else $error("ident reserved bits set");
	feature_high_a: assert property (rd_en && reg_in.addr == `OFS_FEAT_HI
		|=> reg_rdata_q[31:6] == 26'h0 && reg_rdata_q[4] == 1'b0)
		else $error("feature high bits set");
	queue_wrap_a: assert property (ok_done && !wr_qbase && {1'b0, rd_inc} >= q_limit
		|=> rd_ofs_q == 15'h0000)
		else $error("read offset failed to wrap");
	unmapped_drop_a: assert property (wr_db && !dev_mapped_q[db_id] |=> drop_q && !xlate_q.valid)
		else $error("unmapped requester translated");
	bad_write_error_a: assert property (wr_qwlo && new_bad |=> sys_error_q)
		else $error("bad write pointer not flagged");

	// ****************************************************************
	// register port checks
	// ****************************************************************
	// every access is answered one cycle later, writes included
	ack_follows_req_a: assert property (reg_in.req |=> reg_ack_q)
		else $error("access not answered");
	// low word of the write pointer loads the offset field only
	wr_ptr_loads_a: assert property (wr_qwlo |=> wr_ofs_q == $past(new_wr))
		else $error("write pointer not loaded");
	// high word has no writable field, so it must not move the pointer
	hi_write_ignored_a: assert property (wr_en && reg_in.addr == `OFS_QWRITE_HI |=> $stable(wr_ofs_q))
		else $error("high word write moved pointer");
	// stalled flag reads back the halt state of the cycle of the read
	stalled_reads_a: assert property (rd_en && reg_in.addr == `OFS_QREAD_LO
		|=> reg_rdata_q[0] == $past(stalled_q))
		else $error("stalled flag misread");

	// ****************************************************************
	// command queue checks
	// ****************************************************************
	// resume outside a halt must leave the engine as it is
	resume_idle_a: assert property (!stalled_q && resume_wr && !err_done |=> !stalled_q)
		else $error("resume changed idle engine");
	// disabled or invalid queue never starts a fetch
	disabled_no_fetch_a: assert property (!enable_q |=> !fetch_valid_q)
		else $error("fetch while disabled");
	invalid_no_fetch_a: assert property (q_invalid |=> !fetch_valid_q)
		else $error("fetch from invalid queue");
	// rewriting the base restarts reading at offset zero
	base_clears_read_a: assert property (wr_qbase |=> rd_ofs_q == 15'h0000)
		else $error("base write kept read offset");

	// ****************************************************************
	// doorbell translation checks
	// ****************************************************************
	// each doorbell ends in exactly one of translate or drop
	drop_or_take_a: assert property (wr_db |=> drop_q != xlate_q.valid)
		else $error("doorbell result not unique");
	// set bits above the implemented width discard the whole write
	over_width_drop_a: assert property (wr_db && evt_over_impl |=> drop_q && !xlate_q.valid)
		else $error("over-width event translated");
	// a half-word doorbell carries zeros in the upper event bits
	sixteen_bit_event_a: assert property (wr_db && db_accept && !reg_in.be[2] && !reg_in.be[3]
		|=> xlate_q.valid && xlate_q.event_number[31:16] == 16'h0000)
		else $error("half-word doorbell upper bits set");
	// accepted doorbell forwards the requester and all event bits
	event_passes_a: assert property (wr_db && db_accept
		|=> xlate_q.event_number == $past(db_evt) && xlate_q.id == $past(db_id))
		else $error("translation request corrupted");
	// map-device result is kept per requester
	width_kept_a: assert property (map_dev.valid
		|=> dev_width_q[$past(map_dev.id)] == $past(map_dev.width))
		else $error("event width not kept");

endmodule

/* File: xlat_exec_model.sv */
/*
 * command executor model: answers every fetch with one done pulse.
 * assumes fetch pulses from the register block; drives at falling edges.
 */
`timescale 1ns/100ps

module xlat_exec_model (
	input  wire logic        mclk,
	input  wire logic        cmd_fetch_valid,
	input  wire logic [19:0] cmd_fetch_offset,
	input  wire logic [2:0]  lat,
	input  wire logic        err_arm,
	input  wire logic [19:0] err_offset,
	output logic             cmd_done,
	output logic             cmd_error
);
	// ****************************************************************
	// executor
	// ****************************************************************
	// one command in flight, done after lat cycles, error when armed and the fetch offset equals err_offset
	initial begin
		cmd_done = 1'b0;
		cmd_error = 1'b0;
		forever begin
			@(negedge mclk);
			if (cmd_fetch_valid === 1'b1) begin
				repeat (lat) @(negedge mclk);
				cmd_done = 1'b1;
				cmd_error = err_arm && (cmd_fetch_offset == err_offset);
				@(negedge mclk);
				cmd_done = 1'b0;
				cmd_error = 1'b0;
			end
		end
	end
endmodule

/* File: tb.sv */
/*
 * self-checking testbench of the translation service register block.
 * assumes the design files and the executor model are compiled first.
 */
`timescale 1ns/100ps
`include "xlat_defines.svh"

module tb;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic               mclk;
	logic               rst;
	xlat_pkg::reg_req_t reg_in;
	logic [31:0]        reg_rdata;
	logic               reg_ack;
	logic               cmd_fetch_valid;
	logic [19:0]        cmd_fetch_offset;
	logic               cmd_done;
	logic               cmd_error;
	xlat_pkg::map_dev_t map_dev;
	xlat_pkg::map_evt_t map_evt;
	xlat_pkg::xlate_t   xlate_out;
	logic               doorbell_drop;
	logic               sys_error;
	logic [2:0]         lat;
	logic               err_arm;
	logic [19:0]        err_ofs;
	int                 miscompares;
	int                 n_compared;
	int                 sys_errors;
	int                 seed;
	int                 k;
	logic [31:0]        rq[$];
	logic [36:0]        dq[$];
	logic [19:0]        fq[$];

	msi_translation_service_regs msi_translation_service_regs_inst (.mclk(mclk), .rst(rst), .reg_in(reg_in),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .cmd_fetch_valid(cmd_fetch_valid),
		.cmd_fetch_offset(cmd_fetch_offset), .cmd_done(cmd_done), .cmd_error(cmd_error), .map_dev(map_dev),
		.map_evt(map_evt), .xlate_out(xlate_out), .doorbell_drop(doorbell_drop), .sys_error(sys_error));

	xlat_exec_model xlat_exec_model_inst (.mclk(mclk), .cmd_fetch_valid(cmd_fetch_valid),
		.cmd_fetch_offset(cmd_fetch_offset), .lat(lat), .err_arm(err_arm), .err_offset(err_ofs),
		.cmd_done(cmd_done), .cmd_error(cmd_error));

	// ****************************************************************
	// clock, tasks
	// ****************************************************************
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one register access; writes answer with zero data
	task automatic acc(input logic we, input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(negedge mclk);
		reg_in = '{1'b1, we, a, d, 4'hF, 4'h0};
		rq.push_back(exp);
		@(negedge mclk);
		reg_in.req = 1'b0;
	endtask

	// doorbell write from requester id with byte enables
	task automatic db(input logic [3:0] id, input logic [31:0] d, input logic [3:0] be, input logic drop,
		input logic [31:0] ev);
		@(negedge mclk);
		dq.push_back(drop ? {1'b1, 36'h0} : {1'b0, id, ev});
		reg_in = '{1'b1, 1'b1, `OFS_DOORBELL, d, be, id};
		rq.push_back(32'h0);
		@(negedge mclk);
		reg_in.req = 1'b0;
	endtask

	task automatic map_device_cmd(input logic [3:0] id, input logic [4:0] w, input logic [3:0] ev);
		@(negedge mclk);
		map_dev = '{1'b1, id, 1'b1, w};
		@(negedge mclk);
		map_dev.valid = 1'b0;
		map_evt = '{1'b1, id, ev, 1'b1};
		@(negedge mclk);
		map_evt.valid = 1'b0;
	endtask

	task automatic drain();
		int i;
		for (i = 0; i < 2000 && fq.size() != 0; i++) @(negedge mclk);
		repeat (4) @(negedge mclk);
	endtask

	// ****************************************************************
	// monitor
	// ****************************************************************
	// takes the oldest note whenever a result shows
	always @(negedge mclk) begin
		if (reg_ack === 1'b1) begin
			if (rq.size() == 0) check("stray ack", 1, 0);
			else check("reg_rdata", reg_rdata, rq.pop_front());
		end
		if (xlate_out.valid === 1'b1 || doorbell_drop === 1'b1) begin
			if (dq.size() == 0) check("stray doorbell result", 1, 0);
			else check("doorbell", doorbell_drop ? {1'b1, 36'h0} : {1'b0, xlate_out.id, xlate_out.event_number},
				dq.pop_front());
		end
		if (cmd_fetch_valid === 1'b1) begin
			if (fq.size() == 0) check("stray fetch", 1, 0);
			else check("fetch offset", cmd_fetch_offset, fq.pop_front());
		end
		if (sys_error === 1'b1) sys_errors++;
	end

	// watchdog
	initial begin
		#(25 * 20000);
		miscompares++;
		summarize();
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// main sequence
	initial begin
		seed = 73436;
		reg_in = '0;
		map_dev = '0;
		map_evt = '0;
		lat = 3'h0;
		err_ofs = 20'h00020;
		err_arm = 1'b0;
		miscompares = 0;
		n_compared = 0;
		sys_errors = 0;
		rst = 1'b1;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		acc(0, `OFS_IDENT, 0, {`ID_PRODUCT, 4'h0, `ID_VARIANT, `ID_REVISION, `ID_CONT_CODE, 1'b0, `ID_MAKER_CODE});
		acc(0, `OFS_FEAT_LO, 0, {14'h0, 5'(`DEV_BITS - 1), 5'(`EVT_BITS - 1), `FEAT_ITT_SIZE, 3'h0, 1'b1});
		acc(0, `OFS_FEAT_HI, 0, {26'h0, `FEAT_VPE_MOVE, `FEAT_CID_LIMIT, 4'h0});
		acc(0, `OFS_CONTROL, 0, 32'h8000_0000);
		acc(0, 16'h0100, 0, 32'h0);
		acc(1, `OFS_IDENT, 32'hFFFF_FFFF, 32'h0);
		acc(1, `OFS_QWRITE_LO, 32'hFE1 | ($random(seed) & 32'h1E), 32'h0);
		acc(0, `OFS_QWRITE_LO, 0, 32'hFE0);
		acc(1, `OFS_QWRITE_HI, 32'hFFFF_FFFF, 32'h0);
		acc(0, `OFS_QWRITE_HI, 0, 32'h0);
		acc(0, `OFS_QWRITE_LO, 0, 32'hFE0);
		acc(1, `OFS_QWRITE_LO, 32'h1000, 32'h0);
		acc(1, `OFS_QWRITE_LO, 32'h0, 32'h0);
		db(4'h2, $random(seed), 4'hF, 1'b1, 0);
		map_device_cmd(4'h2, 5'd3, 4'h3);
		map_device_cmd(4'h6, 5'd0, 4'h0);
		acc(1, `OFS_CONTROL, 32'h1, 32'h0);
		acc(0, `OFS_CONTROL, 0, 32'h1);
		db(4'h2, 32'h3, 4'hF, 1'b0, 32'h3);
		db(4'h2, 32'hFFFF_0003, 4'h3, 1'b0, 32'h3);
		db(4'h2, 32'h13, 4'hF, 1'b1, 0);
		db(4'h5, $random(seed), 4'hF, 1'b1, 0);
		db(4'h2, 32'h5, 4'hF, 1'b1, 0);
		db(4'h6, 32'h1, 4'hF, 1'b1, 0);
		db(4'h6, 32'h2, 4'hF, 1'b1, 0);
		db(4'h6, 32'h0, 4'hF, 1'b0, 32'h0);
		// command error halts at 0x20 until resume
		lat = 3'($random(seed) & 3);
		err_arm = 1'b1;
		fq.push_back(20'h0);
		fq.push_back(20'h20);
		acc(1, `OFS_QWRITE_LO, 32'h40, 32'h0);
		drain();
		acc(0, `OFS_QREAD_LO, 0, 32'h21);
		err_arm = 1'b0;
		err_ofs = 20'($random(seed));
		acc(1, `OFS_QWRITE_LO, 32'h40, 32'h0);
		drain();
		acc(0, `OFS_QREAD_LO, 0, 32'h21);
		fq.push_back(20'h20);
		acc(1, `OFS_QWRITE_LO, 32'h41, 32'h0);
		drain();
		acc(0, `OFS_QREAD_LO, 0, 32'h40);
		acc(1, `OFS_QWRITE_LO, 32'h41, 32'h0);
		// run to the end of the 4 KB queue and wrap
		for (k = 'h40; k < 'hFE0; k += 'h20) fq.push_back(20'(k));
		acc(1, `OFS_QWRITE_LO, 32'hFE0, 32'h0);
		drain();
		fq.push_back(20'hFE0);
		acc(1, `OFS_QWRITE_LO, 32'h0, 32'h0);
		drain();
		acc(0, `OFS_QREAD_LO, 0, 32'h0);
		// two-page queue: no wrap at 4 KB, base write clears the read offset
		acc(1, `OFS_QBASE_LO, 32'h0000_0301, 32'h0);
		acc(0, `OFS_QBASE_LO, 0, 32'h0000_0001);
		for (k = 0; k < 'h1000; k += 'h20) fq.push_back(20'(k));
		acc(1, `OFS_QWRITE_LO, 32'h1000, 32'h0);
		drain();
		acc(0, `OFS_QREAD_LO, 0, 32'h1000);
		acc(1, `OFS_CONTROL, 32'h0, 32'h0);
		acc(0, `OFS_CONTROL, 0, 32'h8000_0000);
		acc(1, `OFS_QBASE_HI, 32'h0, 32'h0);
		acc(0, `OFS_QREAD_LO, 0, 32'h0);
		repeat (4) @(negedge mclk);
		check("pending notes", rq.size() + dq.size() + fq.size(), 0);
		check("sys_error pulses", sys_errors, 1);
		summarize();
	end
endmodule
